// [design/aelrb_pkg.sv]
package aelrb_pkg;

	// Sector layout
	localparam int        RECS_PER_SEC = 4;
	localparam int        REC_BASE     = 4;
	localparam int        REC_STRIDE   = 124;
	localparam int        ERR_OFS      = 90;
	localparam int        REC_BYTES    = 34;
	localparam int        CNT_OFS      = 500;
	localparam int        CKSUM_OFS    = 511;
	localparam logic [7:0] LOG_VERSION = 8'h01;
	localparam logic [7:0] BYTE_ZERO   = 8'h00;

	// Error data structure offsets
	localparam int OFS_RSVD    = 0;
	localparam int OFS_ERR     = 1;
	localparam int OFS_SCNT    = 2;
	localparam int OFS_LBA     = 4;
	localparam int OFS_DEVHEAD = 10;
	localparam int OFS_STATUS  = 11;
	localparam int OFS_EXT     = 12;
	localparam int EXT_BYTES   = 19;
	localparam int OFS_STATE   = 31;
	localparam int OFS_LIFE    = 32;

	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;

	typedef enum logic [3:0]
	{
		AELRB_ST_UNKNOWN = 4'h0,
		AELRB_ST_SLEEP   = 4'h1,
		AELRB_ST_STANDBY = 4'h2,
		AELRB_ST_ACTIVE  = 4'h3,
		AELRB_ST_SCAN    = 4'h4
	} aelrb_state_t;

endpackage : aelrb_pkg

// [design/aelrb_record_builder.sv]
`timescale 1ns/1ps
`default_nettype none

module aelrb_record_builder #(
	parameter int NSEC = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rstn,
	input  wire logic         i_log_valid,
	input  wire logic         i_dev_fault,
	input  wire logic         i_host_fault,
	input  wire logic [7:0]   i_err_reg,
	input  wire logic [15:0]  i_scnt,
	input  wire logic [15:0]  i_lba_low,
	input  wire logic [15:0]  i_lba_mid,
	input  wire logic [15:0]  i_lba_high,
	input  wire logic [7:0]   i_dev_head,
	input  wire logic [7:0]   i_status,
	input  wire logic [151:0] i_ext_info,
	input  wire logic [3:0]   i_state_code,
	input  wire logic [3:0]   i_state_vendor,
	input  wire logic [15:0]  i_life_hours,
	input  wire logic         i_rd_req,
	input  wire logic [15:0]  i_rd_sector,
	input  wire logic [8:0]   i_rd_byte,
	output logic      [7:0]   o_rd_data,
	output logic              o_rd_valid,
	output logic      [15:0]  o_err_count,
	output logic      [7:0]   o_rec_ptr
);

	localparam int NREC  = NSEC * aelrb_pkg::RECS_PER_SEC;
	localparam int PTR_W = (NREC > 1) ? $clog2(NREC) : 1;
	localparam int NBYTE = NREC * aelrb_pkg::REC_BYTES;

	logic [7:0]       rec_q [NBYTE];
	logic [7:0]       new_rec [aelrb_pkg::REC_BYTES];
	logic [PTR_W-1:0] ptr_q;
	logic [15:0]      cnt_q;
	logic [7:0]       rd_d;
	logic [7:0]       sec_sum;
	logic [3:0]       state_lo;
	int               last_base_q;

	// Record image from post-completion captures
	always_comb
	begin
		for (int j = 0; j < aelrb_pkg::REC_BYTES; j++)
			new_rec[j] = aelrb_pkg::BYTE_ZERO;
		state_lo = (i_state_code > aelrb_pkg::AELRB_ST_SCAN) ? aelrb_pkg::AELRB_ST_UNKNOWN
			: i_state_code;
		new_rec[aelrb_pkg::OFS_RSVD] = aelrb_pkg::BYTE_ZERO;
		new_rec[aelrb_pkg::OFS_ERR] = i_err_reg;
		new_rec[aelrb_pkg::OFS_SCNT]     = i_scnt[7:0];
		new_rec[aelrb_pkg::OFS_SCNT + 1] = i_scnt[15:8];
		new_rec[aelrb_pkg::OFS_LBA]     = i_lba_low[7:0];
		new_rec[aelrb_pkg::OFS_LBA + 1] = i_lba_low[15:8];
		new_rec[aelrb_pkg::OFS_LBA + 2] = i_lba_mid[7:0];
		new_rec[aelrb_pkg::OFS_LBA + 3] = i_lba_mid[15:8];
		new_rec[aelrb_pkg::OFS_LBA + 4] = i_lba_high[7:0];
		new_rec[aelrb_pkg::OFS_LBA + 5] = i_lba_high[15:8];
		new_rec[aelrb_pkg::OFS_DEVHEAD] = i_dev_head;
		new_rec[aelrb_pkg::OFS_STATUS]  = i_status;
		for (int j = 0; j < aelrb_pkg::EXT_BYTES; j++)
			new_rec[aelrb_pkg::OFS_EXT + j] = i_ext_info[8*j +: 8];
		new_rec[aelrb_pkg::OFS_STATE] = {i_state_vendor, state_lo};
		new_rec[aelrb_pkg::OFS_LIFE]     = i_life_hours[7:0];
		new_rec[aelrb_pkg::OFS_LIFE + 1] = i_life_hours[15:8];
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			for (int i = 0; i < NBYTE; i++)
				rec_q[i] <= aelrb_pkg::BYTE_ZERO;
		end
		else if (i_log_valid)
		begin
			for (int j = 0; j < aelrb_pkg::REC_BYTES; j++)
				rec_q[int'(ptr_q) * aelrb_pkg::REC_BYTES + j] <= new_rec[j];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			ptr_q <= '0;
		else if (i_log_valid)
			ptr_q <= (int'(ptr_q) == NREC - 1) ? '0 : ptr_q + 1'b1;
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			cnt_q <= aelrb_pkg::CNT_RESET;
		else if (i_log_valid && i_dev_fault && !i_host_fault && cnt_q != aelrb_pkg::CNT_MAX)
			cnt_q <= cnt_q + 16'h0001;
	end

	// byte sum of the addressed sector
	always_comb
	begin
		sec_sum = aelrb_pkg::BYTE_ZERO;
		if (int'(i_rd_sector) < NSEC)
		begin
			for (int k = 0; k < aelrb_pkg::RECS_PER_SEC; k++)
				for (int j = 0; j < aelrb_pkg::REC_BYTES; j++)
					sec_sum = sec_sum + rec_q[(int'(i_rd_sector) * aelrb_pkg::RECS_PER_SEC
						+ k) * aelrb_pkg::REC_BYTES + j];
			if (i_rd_sector == 16'h0000)
				sec_sum = sec_sum + aelrb_pkg::LOG_VERSION + cnt_q[7:0] + cnt_q[15:8];
		end
	end

	// Sector byte decode
	always_comb
	begin
		int b;
		int rel;
		b = int'(i_rd_byte);
		rel = 0;
		rd_d = aelrb_pkg::BYTE_ZERO;
		if (int'(i_rd_sector) < NSEC)
		begin
			if (b == aelrb_pkg::CKSUM_OFS)
				rd_d = 8'h00 - sec_sum;
			else if (i_rd_sector == 16'h0000 && b == 0)
				rd_d = aelrb_pkg::LOG_VERSION;
			else if (i_rd_sector == 16'h0000 && b == aelrb_pkg::CNT_OFS)
				rd_d = cnt_q[7:0];
			else if (i_rd_sector == 16'h0000 && b == aelrb_pkg::CNT_OFS + 1)
				rd_d = cnt_q[15:8];
			else if (b >= aelrb_pkg::REC_BASE && b < aelrb_pkg::CNT_OFS)
			begin
				for (int k = 0; k < aelrb_pkg::RECS_PER_SEC; k++)
				begin
					rel = b - aelrb_pkg::REC_BASE - k * aelrb_pkg::REC_STRIDE;
					if (rel >= aelrb_pkg::ERR_OFS && rel < aelrb_pkg::REC_STRIDE)
						rd_d = rec_q[(int'(i_rd_sector) * aelrb_pkg::RECS_PER_SEC + k)
							* aelrb_pkg::REC_BYTES + rel - aelrb_pkg::ERR_OFS];
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_rd_data  <= aelrb_pkg::BYTE_ZERO;
			o_rd_valid <= 1'b0;
		end
		else
		begin
			o_rd_data  <= i_rd_req ? rd_d : o_rd_data;
			o_rd_valid <= i_rd_req;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_err_count <= aelrb_pkg::CNT_RESET;
			o_rec_ptr   <= 8'h00;
			last_base_q <= 0;
		end
		else
		begin
			o_err_count <= (i_log_valid && i_dev_fault && !i_host_fault
				&& cnt_q != aelrb_pkg::CNT_MAX) ? cnt_q + 16'h0001 : cnt_q;
			o_rec_ptr   <= 8'(i_log_valid ? ((int'(ptr_q) == NREC - 1) ? 0
				: int'(ptr_q) + 1) : int'(ptr_q));
			if (i_log_valid)
				last_base_q <= int'(ptr_q) * aelrb_pkg::REC_BYTES;
		end
	end

	sequence s_log;
		i_log_valid;
	endsequence

	property p_err_byte;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_log |=> rec_q[last_base_q + aelrb_pkg::OFS_ERR] == $past(i_err_reg);
	endproperty
	a_err_byte: assert property (p_err_byte) else $error("error byte not stored");

	property p_scnt;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_log |=> rec_q[last_base_q + aelrb_pkg::OFS_SCNT] == $past(i_scnt[7:0])
			&& rec_q[last_base_q + aelrb_pkg::OFS_SCNT + 1] == $past(i_scnt[15:8]);
	endproperty
	a_scnt: assert property (p_scnt) else $error("sector count bytes wrong");

	property p_lba_high;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_log |=> rec_q[last_base_q + aelrb_pkg::OFS_LBA + 5] == $past(i_lba_high[15:8]);
	endproperty
	a_lba_high: assert property (p_lba_high) else $error("address high byte wrong");

	property p_status;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_log |=> rec_q[last_base_q + aelrb_pkg::OFS_STATUS] == $past(i_status)
			&& rec_q[last_base_q + aelrb_pkg::OFS_DEVHEAD] == $past(i_dev_head);
	endproperty
	a_status: assert property (p_status) else $error("status or device byte wrong");

	property p_state;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_log |=> rec_q[last_base_q + aelrb_pkg::OFS_STATE][3:0] <= 4'h4;
	endproperty
	a_state: assert property (p_state) else $error("reserved state code stored");

	property p_life;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_log |=> rec_q[last_base_q + aelrb_pkg::OFS_LIFE + 1] == $past(i_life_hours[15:8]);
	endproperty
	a_life: assert property (p_life) else $error("life timestamp wrong");

	property p_cnt_inc;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_log ##0 (i_dev_fault && !i_host_fault && cnt_q != aelrb_pkg::CNT_MAX)
			|=> o_err_count == $past(cnt_q) + 16'h0001;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("error count did not step");

	property p_cnt_host;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_host_fault || !i_dev_fault) |=> $stable(cnt_q);
	endproperty
	a_cnt_host: assert property (p_cnt_host) else $error("host fault counted");

	property p_cnt_sat;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		cnt_q == aelrb_pkg::CNT_MAX |=> cnt_q == aelrb_pkg::CNT_MAX;
	endproperty
	a_cnt_sat: assert property (p_cnt_sat) else $error("error count left maximum");

	property p_version;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		i_rd_req && i_rd_sector == 16'h0000 && i_rd_byte == 9'h000
			|=> o_rd_valid && o_rd_data == 8'h01;
	endproperty
	a_version: assert property (p_version) else $error("version byte wrong");

	property p_cksum;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		i_rd_req && i_rd_byte == 9'h1FF |=> 8'(o_rd_data + $past(sec_sum)) == 8'h00;
	endproperty
	a_cksum: assert property (p_cksum) else $error("checksum does not close sector");

	property p_rsvd;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_log |=> rec_q[last_base_q] == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");

endmodule : aelrb_record_builder

`default_nettype wire

// [bench/aelrb_host_reader.sv]
`timescale 1ns/1ps
`default_nettype none

module aelrb_host_reader (
	input  wire logic       i_clk_sys,
	input  wire logic       i_go,
	input  wire logic [7:0] i_rd_data,
	input  wire logic       i_rd_valid,
	output logic            o_rd_req,
	output logic      [8:0] o_rd_byte,
	output logic            o_done,
	output logic            o_sum_ok
);
	logic [7:0] mem [0:511];
	logic [8:0] last_q;
	logic [7:0] sum;
	int         n_valid;

	initial
	begin
		o_rd_req  = 1'b0;
		o_rd_byte = 9'h000;
		o_done    = 1'b0;
		o_sum_ok  = 1'b0;
	end

	// Whole sector, one byte request per cycle
	always @(posedge i_go)
	begin
		o_done  = 1'b0;
		n_valid = 0;
		for (int b = 0; b < 512; b++)
		begin
			@(negedge i_clk_sys);
			n_valid += int'(i_rd_valid);
			o_rd_req  = 1'b1;
			o_rd_byte = 9'(b);
		end
		@(negedge i_clk_sys);
		n_valid += int'(i_rd_valid);
		o_rd_req  = 1'b0;
		o_rd_byte = ~o_rd_byte;
		@(negedge i_clk_sys);
		n_valid += int'(i_rd_valid);
		sum = 8'h00;
		for (int b = 0; b < 512; b++)
			sum += mem[b];
		o_sum_ok = (sum == 8'h00);
		o_done   = 1'b1;
	end

	always @(posedge i_clk_sys)
	begin
		if (o_rd_req)
			last_q <= o_rd_byte;
		if (i_rd_valid)
			mem[last_q] <= i_rd_data;
	end
endmodule : aelrb_host_reader

`default_nettype wire

// [bench/aelrb_record_builder_test.sv]
`timescale 1ns/1ps
`default_nettype none

module aelrb_record_builder_test;
	logic         clk_sys, rstn, log_v, dev_f, host_f, go, done, sum_ok, rd_req, rd_vld;
	logic [7:0]   base, rd_data, ptr;
	logic [8:0]   rd_byte;
	logic [3:0]   st_code, st_vend;
	logic [151:0] ext;
	logic [15:0]  err_cnt, cnt, rd_sec;
	logic [7:0]   exp_q [0:511];
	int           nrec, errors, cmp_count;
	int           cyc = 0;

	always_comb
		for (int j = 0; j < 19; j++)
			ext[8*j +: 8] = base + 8'(12 + j);

	aelrb_record_builder #(.NSEC(1)) uut (
		.i_clk_sys(clk_sys), .i_rstn(rstn), .i_log_valid(log_v),
		.i_dev_fault(dev_f), .i_host_fault(host_f), .i_err_reg(base + 8'h01),
		.i_scnt({base + 8'h03, base + 8'h02}), .i_lba_low({base + 8'h05, base + 8'h04}),
		.i_lba_mid({base + 8'h07, base + 8'h06}), .i_lba_high({base + 8'h09, base + 8'h08}),
		.i_dev_head(base + 8'h0A), .i_status(base + 8'h0B), .i_ext_info(ext),
		.i_state_code(st_code), .i_state_vendor(st_vend),
		.i_life_hours({base + 8'h21, base + 8'h20}), .i_rd_req(rd_req),
		.i_rd_sector(rd_sec), .i_rd_byte(rd_byte), .o_rd_data(rd_data),
		.o_rd_valid(rd_vld), .o_err_count(err_cnt), .o_rec_ptr(ptr));

	aelrb_host_reader host (
		.i_clk_sys(clk_sys), .i_go(go), .i_rd_data(rd_data), .i_rd_valid(rd_vld),
		.o_rd_req(rd_req), .o_rd_byte(rd_byte), .o_done(done), .o_sum_ok(sum_ok));

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task give_verdict();
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	task chk(input string name, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	// Holds log valid high; caller lowers it
	task log_rec(input logic d, input logic h, input logic [7:0] b, input logic [3:0] c,
		input logic [3:0] v);
		int s;
		{base, dev_f, host_f, st_code, st_vend, log_v} = {b, d, h, c, v, 1'b1};
		s = 94 + 124 * (nrec % 4);
		exp_q[s] = 8'h00;
		for (int i = 1; i < 34; i++)
			exp_q[s + i] = b + 8'(i);
		exp_q[s + 31] = {v, (c > 4'h4) ? 4'h0 : c};
		if (d && !h && cnt != 16'hFFFF)
			cnt++;
		{exp_q[501], exp_q[500]} = cnt;
		nrec++;
		@(negedge clk_sys);
	endtask : log_rec

	task run_reader();
		go = 1'b1;
		@(negedge clk_sys);
		go = 1'b0;
		for (int w = 0; w < 600 && done !== 1'b1; w++)
			@(negedge clk_sys);
		chk("read done", 16'h0001, {15'h0000, done});
		chk("valid count", 16'h0200, 16'(host.n_valid));
	endtask : run_reader

	task read_check();
		logic [7:0] sum;
		run_reader();
		sum = 8'h00;
		for (int i = 0; i < 511; i++)
		begin
			chk("sector byte", {8'h00, exp_q[i]}, {8'h00, host.mem[i]});
			sum += exp_q[i];
		end
		chk("checksum", {8'h00, 8'(~sum + 8'h01)}, {8'h00, host.mem[511]});
		chk("sum ok", 16'h0001, {15'h0000, sum_ok});
		chk("count", cnt, err_cnt);
		chk("pointer", 16'(nrec % 4), {8'h00, ptr});
	endtask : read_check

	task t_fields();
		log_rec(1'b1, 1'b0, 8'h10, 4'h3, 4'hA);
		log_v = 1'b0;
		read_check();
	endtask : t_fields

	task t_codes_faults();
		for (int c = 0; c < 6; c++)
			log_rec(c != 0 && c != 4, c == 2, 8'h40 + 8'(c * 16), 4'(c), 4'(15 - c));
		log_v = 1'b0;
		read_check();
	endtask : t_codes_faults

	task t_far_sector();
		rd_sec = 16'h0001;
		run_reader();
		for (int i = 0; i < 512; i++)
			chk("far sector byte", 16'h0000, {8'h00, host.mem[i]});
		chk("far sum ok", 16'h0001, {15'h0000, sum_ok});
		rd_sec = 16'h0000;
	endtask : t_far_sector

	task t_saturate();
		for (int n = 0; n < 65540; n++)
			log_rec(1'b1, 1'b0, 8'hC0, 4'h2, 4'h5);
		log_v = 1'b0;
		read_check();
	endtask : t_saturate

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			errors++;
			give_verdict();
		end
	end

	initial
	begin
		{log_v, dev_f, host_f, go, rstn} = 5'h00;
		{base, st_code, st_vend} = 16'h0000;
		cnt       = 16'h0000;
		rd_sec    = 16'h0000;
		nrec      = 0;
		errors    = 0;
		cmp_count = 0;
		for (int i = 0; i < 512; i++)
			exp_q[i] = 8'h00;
		exp_q[0] = 8'h01;
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		read_check();
		t_fields();
		t_codes_faults();
		t_far_sector();
		t_saturate();
		give_verdict();
	end
endmodule : aelrb_record_builder_test

`default_nettype wire
